/* hw/aets_mux8.sv */
`timescale 1ns/100ps
module aets_mux8
  import aets_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] src,
  input wire logic [2:0] sel,
  output logic trig
);
  logic trig_nxt;
  always_comb begin
    trig_nxt = src[sel];
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig <= 1'b0;
    end else begin
      trig <= trig_nxt;
    end
  end
endmodule : aets_mux8

/* hw/aets_top.sv */
`timescale 1ns/100ps
module aets_top
  import aets_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adc1_event_pin,
  input wire logic adc2_event_pin,
  input wire logic [31:0] timer_a_channel,
  input wire logic [31:0] timer_b_channel,
  input wire logic [1:0] gpio_port_b,
  input wire logic rtos_timer_compare0,
  output logic [2:0] conv1_trig,
  output logic [2:0] conv2_trig,
  output logic [1:0] conv_alt_wiring
);
  // mux control bits and select fields
  logic [1:0] mux_r, mux_nxt;
  logic [17:0] sel_r, sel_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic alt_sel;
  logic [7:0] src_def, src_alt, src_c1, src_c2;
  logic [5:0] trig_w;

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // bit 0 wins; both zero falls back to default
  assign alt_sel = !mux_r[AETS_MUX_DEF_BIT] && mux_r[AETS_MUX_ALT_BIT];

  // pad-side levels straight in, no pin-function gating
  assign src_def = {gpio_port_b[1], gpio_port_b[0], timer_a_channel[14],
    timer_a_channel[12], rtos_timer_compare0, timer_a_channel[10],
    timer_a_channel[8], 1'b0};
  // timer boundary signals, independent of pad routing
  assign src_alt = {timer_b_channel[13], timer_a_channel[11],
    timer_a_channel[19], timer_a_channel[17], rtos_timer_compare0,
    timer_a_channel[27], timer_b_channel[5], 1'b0};

  always_comb begin
    src_c1 = alt_sel ? src_alt : src_def;
    src_c2 = alt_sel ? src_alt : src_def;
    src_c1[AETS_SRC_PIN] = adc1_event_pin;
    src_c2[AETS_SRC_PIN] = adc2_event_pin;
  end

  // one selector per group per converter
  for (genvar g = 0; g < 6; g++) begin : g_grp
    aets_mux8 u_mux (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .src(g < AETS_NUM_GRP ? src_c1 : src_c2),
      .sel(sel_r[g*AETS_SEL_W +: AETS_SEL_W]),
      .trig(trig_w[g])
    );
  end

  assign conv1_trig = trig_w[2:0];
  assign conv2_trig = trig_w[5:3];
  assign conv_alt_wiring = {alt_sel, alt_sel};

  // axi write path: address and data in either order
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_comb begin
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] cur;
    a = 12'h000;
    d = 32'h00000000;
    s = 4'h0;
    cur = 32'h00000000;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    mux_nxt = mux_r;
    sel_nxt = sel_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_got_r && w_got_r) begin
      a = {awaddr_r[11:2], 2'h0};
      d = wdata_r;
      s = wstrb_r;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = AETS_RESP_OKAY;
      if (a == AETS_OFF_MUX) begin
        cur = strb_merge({30'h0, mux_r}, d, s);
        mux_nxt = cur[1:0];
      end else if (a == AETS_OFF_SEL) begin
        cur = strb_merge({7'h0, sel_r[17:9], 7'h0, sel_r[8:0]}, d, s);
        sel_nxt = {cur[AETS_SEL_C2_LSB +: 9], cur[8:0]};
      end else if (a == AETS_OFF_STAT) begin
        bresp_nxt = AETS_RESP_OKAY;
      end else begin
        bresp_nxt = AETS_RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    logic [11:0] ra;
    ra = {s_axi_araddr[11:2], 2'h0};
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = AETS_RESP_OKAY;
      if (ra == AETS_OFF_MUX) begin
        rdata_nxt = {30'h0, mux_r};
      end else if (ra == AETS_OFF_SEL) begin
        rdata_nxt = {7'h0, sel_r[17:9], 7'h0, sel_r[8:0]};
      end else if (ra == AETS_OFF_STAT) begin
        // live trigger levels and wiring in use
        rdata_nxt = {23'h0, alt_sel, 2'h0, trig_w};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = AETS_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_r <= AETS_MUX_RST;
      sel_r <= AETS_SEL_RST;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= AETS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= AETS_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      mux_r <= mux_nxt;
      sel_r <= sel_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  a_c1_def_path: assert property (@(posedge core_clk) disable iff (!rst_b)
    !alt_sel |=> conv1_trig[0] == $past(src_def[sel_r[2:0]]) ||
    sel_r[2:0] == AETS_SRC_PIN || $past(sel_r[2:0]) != sel_r[2:0] ||
    $past(alt_sel))
    else $error("converter one default path wrong");
  a_c1_alt_path: assert property (@(posedge core_clk) disable iff (!rst_b)
    alt_sel && $stable(alt_sel) && $stable(sel_r[5:3]) &&
    sel_r[5:3] != AETS_SRC_PIN |=> conv1_trig[1] == $past(src_alt[sel_r[5:3]]))
    else $error("converter one alternate path wrong");
  a_c2_def_path: assert property (@(posedge core_clk) disable iff (!rst_b)
    !alt_sel && $stable(sel_r[11:9]) && $stable(alt_sel) &&
    sel_r[11:9] != AETS_SRC_PIN |=> conv2_trig[0] == $past(src_def[sel_r[11:9]]))
    else $error("converter two default path wrong");
  a_c2_alt_path: assert property (@(posedge core_clk) disable iff (!rst_b)
    alt_sel && $stable(sel_r[17:15]) && $stable(alt_sel) &&
    sel_r[17:15] != AETS_SRC_PIN |=>
    conv2_trig[2] == $past(src_alt[sel_r[17:15]]))
    else $error("converter two alternate path wrong");
  a_def_bit_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
    mux_r[AETS_MUX_DEF_BIT] |-> !alt_sel)
    else $error("default bit must force default wiring");
  a_alt_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
    !mux_r[AETS_MUX_DEF_BIT] && mux_r[AETS_MUX_ALT_BIT] |->
    conv_alt_wiring == 2'h3)
    else $error("alternate wiring not in use");
  a_zero_fallback: assert property (@(posedge core_clk) disable iff (!rst_b)
    mux_r == 2'h0 |-> conv_alt_wiring == 2'h0)
    else $error("both bits zero must give default");
  a_pin_ungated: assert property (@(posedge core_clk) disable iff (!rst_b)
    sel_r[2:0] == AETS_SRC_PIN && $stable(sel_r[2:0]) |=>
    conv1_trig[0] == $past(adc1_event_pin))
    else $error("event pin trigger gated");
  a_cmp0_direct: assert property (@(posedge core_clk) disable iff (!rst_b)
    sel_r[8:6] == AETS_SRC_RTOS && $stable(sel_r[8:6]) |=>
    conv1_trig[2] == $past(rtos_timer_compare0))
    else $error("compare 0 not passed through");
  a_alt_timer: assert property (@(posedge core_clk) disable iff (!rst_b)
    alt_sel && $stable(alt_sel) && sel_r[14:12] == 3'h2 &&
    $stable(sel_r[14:12]) |=> conv2_trig[1] == $past(timer_a_channel[27]))
    else $error("alternate timer trigger wrong");
endmodule : aets_top

/* pkg/aets_pkg.sv */
package aets_pkg;
  localparam int AETS_NUM_CONV = 2;
  localparam int AETS_NUM_GRP = 3;
  localparam int AETS_SEL_W = 3;
  localparam int AETS_NUM_SRC = 8;
  // group index order within a converter
  localparam int AETS_GRP_EVT = 0;
  localparam int AETS_GRP_G1 = 1;
  localparam int AETS_GRP_G2 = 2;
  // source codes
  localparam logic [2:0] AETS_SRC_PIN = 3'h0;
  localparam logic [2:0] AETS_SRC_RTOS = 3'h3;
  // register byte offsets
  localparam logic [11:0] AETS_OFF_MUX = 12'h000;
  localparam logic [11:0] AETS_OFF_SEL = 12'h004;
  localparam logic [11:0] AETS_OFF_STAT = 12'h008;
  // field positions
  localparam int AETS_MUX_DEF_BIT = 0;
  localparam int AETS_MUX_ALT_BIT = 1;
  localparam int AETS_SEL_C2_LSB = 16;
  // reset values and response codes
  localparam logic [1:0] AETS_MUX_RST = 2'h1;
  localparam logic [17:0] AETS_SEL_RST = 18'h00000;
  localparam logic [1:0] AETS_RESP_OKAY = 2'h0;
  localparam logic [1:0] AETS_RESP_SLVERR = 2'h2;
endpackage : aets_pkg

/* tb/adc_event_trigger_select_tb.sv */
`timescale 1ns/100ps
module adc_event_trigger_select_tb;
  import aets_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd_a = 32'h0, rnd_b = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, gpio_port_b, conv_alt_wiring, rsp;
  logic adc1_event_pin, adc2_event_pin, rtos_timer_compare0, alt;
  logic [31:0] timer_a_channel, timer_b_channel, rd, seed_r;
  logic [2:0] conv1_trig, conv2_trig, e1, e2;
  int fail_count = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  aets_src_model u_src (.core_clk(core_clk), .rst_b(rst_b), .rnd_a(rnd_a),
    .rnd_b(rnd_b), .adc1_event_pin(adc1_event_pin),
    .adc2_event_pin(adc2_event_pin), .timer_a_channel(timer_a_channel),
    .timer_b_channel(timer_b_channel), .gpio_port_b(gpio_port_b),
    .rtos_timer_compare0(rtos_timer_compare0));
  aets_top u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .adc1_event_pin(adc1_event_pin),
    .adc2_event_pin(adc2_event_pin), .timer_a_channel(timer_a_channel),
    .timer_b_channel(timer_b_channel), .gpio_port_b(gpio_port_b),
    .rtos_timer_compare0(rtos_timer_compare0), .conv1_trig(conv1_trig),
    .conv2_trig(conv2_trig), .conv_alt_wiring(conv_alt_wiring));
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    r = 2'bxx;
    b_hs = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung wait
    while (!b_hs) begin
      // levels settled mid-cycle are the ones the next edge sees
      @(negedge core_clk);
      aw_hs = s_axi_awvalid && s_axi_awready === 1'b1;
      w_hs = s_axi_wvalid && s_axi_wready === 1'b1;
      b_hs = s_axi_bvalid === 1'b1 && s_axi_bready;
      if (b_hs) r = s_axi_bresp;
      @(posedge core_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic ar_hs, r_hs;
    r = 2'bxx;
    d = 'x;
    r_hs = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!r_hs) begin
      @(negedge core_clk);
      ar_hs = s_axi_arvalid && s_axi_arready === 1'b1;
      r_hs = s_axi_rvalid === 1'b1 && s_axi_rready;
      if (r_hs) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      @(posedge core_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
    end
  endtask : axi_rd
  // reference routing, one table per wiring
  function automatic logic pick(input bit c2, input logic al,
      input logic [2:0] c);
    logic [7:0] d, s;
    d = {gpio_port_b, timer_a_channel[14], timer_a_channel[12],
      rtos_timer_compare0, timer_a_channel[10], timer_a_channel[8],
      c2 ? adc2_event_pin : adc1_event_pin};
    s = {timer_b_channel[13], timer_a_channel[11], timer_a_channel[19],
      timer_a_channel[17], rtos_timer_compare0, timer_a_channel[27],
      timer_b_channel[5], d[0]};
    return al ? s[c] : d[c];
  endfunction : pick
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
  initial begin
    seed_r = 32'h0000FD8B;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    axi_rd(AETS_OFF_MUX, rd, rsp);
    chk(rd, 32'h1);
    axi_rd(AETS_OFF_SEL, rd, rsp);
    chk(rd, 32'h0);
    // only the low byte lane may land
    s_axi_wstrb <= 4'h1;
    axi_wr(AETS_OFF_SEL, 32'hFFFFFFFF, rsp);
    s_axi_wstrb <= 4'hF;
    axi_rd(AETS_OFF_SEL, rd, rsp);
    chk(rd, 32'h000000FF);
    axi_wr(12'h00C, 32'h5, rsp);
    chk(rsp, AETS_RESP_SLVERR);
    axi_rd(12'h00C, rd, rsp);
    chk(rd, 32'h0);
    chk(rsp, AETS_RESP_SLVERR);
    axi_wr(AETS_OFF_STAT, 32'hFFFFFFFF, rsp);
    chk(rsp, AETS_RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      axi_wr(AETS_OFF_MUX, m, rsp);
      axi_rd(AETS_OFF_MUX, rd, rsp);
      chk(rd, m);
      alt = (m == 2);
      for (int c = 0; c < 8; c++) begin
        // each group of each converter gets its own code
        axi_wr(AETS_OFF_SEL, {7'h0, 3'(c + 5), 3'(c + 4), 3'(c + 3), 7'h0,
          3'(c + 2), 3'(c + 1), 3'(c)}, rsp);
        for (int k = 0; k < 4; k++) begin
          seed_r = xs(seed_r);
          rnd_a <= seed_r;
          seed_r = xs(seed_r);
          rnd_b <= seed_r;
          repeat (4) @(posedge core_clk);
          e1 = {pick(0, alt, 3'(c + 2)), pick(0, alt, 3'(c + 1)),
            pick(0, alt, 3'(c))};
          e2 = {pick(1, alt, 3'(c + 5)), pick(1, alt, 3'(c + 4)),
            pick(1, alt, 3'(c + 3))};
          chk(conv1_trig, e1);
          chk(conv2_trig, e2);
          chk(conv_alt_wiring, {alt, alt});
        end
        axi_rd(AETS_OFF_STAT, rd, rsp);
        chk(rd, {23'h0, alt, 2'h0, e2, e1});
      end
    end
    stop_test();
  end
endmodule : adc_event_trigger_select_tb

/* tb/aets_src_model.sv */
`timescale 1ns/100ps
module aets_src_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [31:0] rnd_a,
  input wire logic [31:0] rnd_b,
  output logic adc1_event_pin,
  output logic adc2_event_pin,
  output logic [31:0] timer_a_channel,
  output logic [31:0] timer_b_channel,
  output logic [1:0] gpio_port_b,
  output logic rtos_timer_compare0
);
  // sources move only on the clock, as on-chip timers and pads do
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc1_event_pin <= 1'b0;
      adc2_event_pin <= 1'b0;
      timer_a_channel <= 32'h0;
      timer_b_channel <= 32'h0;
      gpio_port_b <= 2'h0;
      rtos_timer_compare0 <= 1'b0;
    end else begin
      timer_a_channel <= rnd_a;
      timer_b_channel <= rnd_b;
      // pad level only, no function gating seen by the converter
      gpio_port_b <= rnd_a[1:0] ^ rnd_b[31:30];
      adc1_event_pin <= rnd_b[0] ^ rnd_a[31];
      adc2_event_pin <= rnd_b[1] ^ rnd_a[30];
      rtos_timer_compare0 <= rnd_b[2] ^ rnd_a[29];
    end
  end
endmodule : aets_src_model
